// ==== hdl/ifa_defines.vh ====
/*
 * ifa_defines.vh: register offsets, field positions, mode codes and reset
 * values of the input function assignment block.
 * Assumes inclusion by bare name from the design files under hdl/.
 */
`ifndef IFA_DEFINES_VH
`define IFA_DEFINES_VH

// register indices; byte address is index times four
`define IFA_IDX_CNT_LOW      10'h190
`define IFA_IDX_CNT_HIGH     10'h191
`define IFA_IDX_PCATCH       10'h192
`define IFA_IDX_INTSEL       10'h193
`define IFA_IDX_INTSTAT      10'h194
`define IFA_IDX_INTMASK      10'h195
`define IFA_IDX_CNTA         10'h196
`define IFA_IDX_CNTB         10'h197
`define IFA_IDX_CNTC         10'h198
`define IFA_IDX_CNTD         10'h199
`define IFA_IDX_ROUTE        10'h19A

// counter-mode register: first channel in [3:0], second in [7:4]
`define IFA_FIRST_LSB        0
`define IFA_SECOND_LSB       4

// first-channel mode codes
`define IFA_M1_OFF           4'h0
`define IFA_M1_QUAD          4'h1
`define IFA_M1_QUAD_RST      4'h2
`define IFA_M1_UP            4'h3
`define IFA_M1_UP_RST        4'h4
`define IFA_M1_DN            4'h5
`define IFA_M1_DN_RST        4'h6
`define IFA_M1_UPDN          4'h7
`define IFA_M1_UPDN_RST      4'h8
`define IFA_M1_DIR           4'h9
`define IFA_M1_DIR_RST       4'hA

// second-channel mode codes
`define IFA_M2_OFF           4'h0
`define IFA_M2_UP            4'h1
`define IFA_M2_UP_RST        4'h2
`define IFA_M2_DN            4'h3
`define IFA_M2_DN_RST        4'h4

// interrupt select: enables in [7:0], falling-edge selects in [15:8]
`define IFA_INT_EN_LSB       0
`define IFA_INT_FALL_LSB     8

// reset values
`define IFA_RST_CFG          16'h0000
`define IFA_RST_BYTE         8'h00
`define IFA_RST_CNT          16'h0000

`endif

// ==== hdl/ifa_edge_det.v ====
/*
 * ifa_edge_det.v: rising and falling edge detector for one input.
 * Assumes the input is already synchronous to mclk.
 */
`default_nettype none

module ifa_edge_det (
   input  wire mclk,
   input  wire nrst,
   input  wire sigIn,
   output wire rise,
   output wire fall
);
   reg         prev_q;

   // previous sample; idle low after reset
   always @(posedge mclk) begin
      if (!nrst)
         prev_q <= 1'b0;
      else
         prev_q <= sigIn;
   end

   assign rise = sigIn & ~prev_q;
   assign fall = ~sigIn & prev_q;
endmodule // ifa_edge_det

`default_nettype wire

// ==== hdl/ifa_counter_pair.v ====
/*
 * ifa_counter_pair.v: one pair of counter channels fed from three inputs
 * (first pulse, second pulse, shared reset).
 * Assumes edge pulses from ifa_edge_det and mode fields from registers.
 */
`default_nettype none
`include "ifa_defines.vh"

module ifa_counter_pair (
   input  wire        mclk,
   input  wire        nrst,
   input  wire [3:0]  modeFirst,
   input  wire [3:0]  modeSecond,
   input  wire [2:0]  level,
   input  wire [2:0]  rise,
   input  wire [2:0]  fall,
   output reg  [15:0] countFirst_q,
   output reg  [15:0] countSecond_q,
   output wire [2:0]  claimed
);
   wire        firstOn;
   wire        twoInput;
   wire        secondOn;
   wire        firstRstReq;
   wire        secondRstReq;
   wire        secondRstOwn;
   wire        firstRstOwn;
   wire        quadStep;
   wire        quadUp;
   reg         incA;
   reg         decA;
   reg         incB;
   reg         decB;

   assign firstOn  = (modeFirst != `IFA_M1_OFF) &&
                     (modeFirst <= `IFA_M1_DIR_RST);
   assign twoInput = (modeFirst == `IFA_M1_QUAD) ||
                     (modeFirst == `IFA_M1_QUAD_RST) ||
                     (modeFirst == `IFA_M1_UPDN) ||
                     (modeFirst == `IFA_M1_UPDN_RST) ||
                     (modeFirst == `IFA_M1_DIR) ||
                     (modeFirst == `IFA_M1_DIR_RST);
   // second channel config ignored under a two-input first mode
   assign secondOn = !twoInput && (modeSecond != `IFA_M2_OFF) &&
                     (modeSecond <= `IFA_M2_DN_RST); // [RQ9] [RQ10]
   assign firstRstReq  = (modeFirst == `IFA_M1_QUAD_RST) ||
                         (modeFirst == `IFA_M1_UP_RST) ||
                         (modeFirst == `IFA_M1_DN_RST) ||
                         (modeFirst == `IFA_M1_UPDN_RST) ||
                         (modeFirst == `IFA_M1_DIR_RST);
   assign secondRstReq = secondOn && ((modeSecond == `IFA_M2_UP_RST) ||
                         (modeSecond == `IFA_M2_DN_RST));
   // shared reset goes to the second channel when both claim it
   assign secondRstOwn = secondRstReq; // [RQ11]
   assign firstRstOwn  = firstRstReq && !secondRstReq; // [RQ11]

   assign claimed[0] = firstOn;
   assign claimed[1] = twoInput || secondOn;
   assign claimed[2] = firstRstReq || secondRstReq;

   // x2 quadrature: both edges of phase A count, phase B gives direction
   assign quadStep = rise[0] | fall[0]; // [RQ2]
   assign quadUp   = rise[0] ? ~level[1] : level[1];

   // first-channel step decode
   always @* begin
      incA = 1'b0;
      decA = 1'b0;
      case (modeFirst)
         `IFA_M1_QUAD, `IFA_M1_QUAD_RST: begin // [RQ2]
            incA = quadStep & quadUp;
            decA = quadStep & ~quadUp;
         end
         `IFA_M1_UP, `IFA_M1_UP_RST: incA = rise[0]; // [RQ3]
         `IFA_M1_DN, `IFA_M1_DN_RST: decA = rise[0]; // [RQ3]
         `IFA_M1_UPDN, `IFA_M1_UPDN_RST: begin // [RQ4]
            incA = rise[0] & ~rise[1];
            decA = rise[1] & ~rise[0];
         end
         `IFA_M1_DIR, `IFA_M1_DIR_RST: begin // [RQ5]
            incA = rise[0] & ~level[1];
            decA = rise[0] & level[1];
         end
         default: begin
            incA = 1'b0;
            decA = 1'b0;
         end
      endcase
   end

   // second-channel step decode on the second input
   always @* begin
      incB = 1'b0;
      decB = 1'b0;
      if (secondOn) begin
         case (modeSecond)
            `IFA_M2_UP, `IFA_M2_UP_RST: incB = rise[1]; // [RQ6] [RQ8]
            `IFA_M2_DN, `IFA_M2_DN_RST: decB = rise[1]; // [RQ6] [RQ8]
            default: begin
               incB = 1'b0;
               decB = 1'b0;
            end
         endcase
      end
   end

   // counters; reset input clears while high and beats a step
   always @(posedge mclk) begin
      if (!nrst) begin
         countFirst_q  <= `IFA_RST_CNT;
         countSecond_q <= `IFA_RST_CNT;
      end else begin
         if (!firstOn)
            countFirst_q <= `IFA_RST_CNT; // [RQ1]
         else if (firstRstOwn && level[2])
            countFirst_q <= `IFA_RST_CNT;
         else if (incA)
            countFirst_q <= countFirst_q + 16'h0001;
         else if (decA)
            countFirst_q <= countFirst_q - 16'h0001;
         if (!secondOn)
            countSecond_q <= `IFA_RST_CNT;
         else if (secondRstOwn && level[2])
            countSecond_q <= `IFA_RST_CNT;
         else if (incB)
            countSecond_q <= countSecond_q + 16'h0001;
         else if (decB)
            countSecond_q <= countSecond_q - 16'h0001;
      end
   end
endmodule // ifa_counter_pair

`default_nettype wire

// ==== hdl/ifa_input_assign.v ====
/*
 * ifa_input_assign.v: top of the input function assignment block.
 * Four counter channels on inputs 0..5, pulse catch and edge interrupts
 * on inputs 0..7, arbitrated per input; registers on a plain port.
 * Assumes inputs synchronous to mclk and a master that never waits.
 */
// Chosen here: the strobed register port.
// Functional notes
// RQ1: first channel off by default, input free
// RQ2: first channel two-phase, optional reset input
// RQ3: first channel up or down, optional reset
// RQ4: first channel separate up/down pulses, optional reset
// RQ5: first channel pulse plus direction, optional reset
// RQ6: second channel off, else up/down on input_1
// RQ7: third channel mirrors first on inputs 3-5
// RQ8: fourth channel off, else up/down on input_4
// RQ9: two-input first mode ignores second channel
// RQ10: two-input third mode ignores fourth channel
// RQ11: shared reset overlap goes to second channel
// RQ12: per-input pulse catch select, default clear
// RQ13: per-input interrupt enable, default clear
// RQ14: edge select set means falling edge
// RQ15: priority counter, then pulse catch, then interrupt
// RQ16: edge select clear means rising edge
`default_nettype none
`include "ifa_defines.vh"

module ifa_input_assign (
   input  wire        mclk,
   input  wire        nrst,
   input  wire [7:0]  inPins,
   input  wire [11:0] regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdata_q,
   output wire [7:0]  inputLevel,
   output wire        irq
);
   wire [9:0]  regIdx;
   reg  [15:0] cntLow_q;
   reg  [15:0] cntHigh_q;
   reg  [7:0]  pcatch_q;
   reg  [15:0] intSel_q;
   reg  [7:0]  intStat_q;
   reg  [7:0]  intMask_q;
   reg  [7:0]  caught_q;
   reg  [31:0] rdata_d;
   wire [7:0]  rise;
   wire [7:0]  fall;
   wire [2:0]  claimLow;
   wire [2:0]  claimHigh;
   wire [7:0]  cntClaim;
   wire [7:0]  pcActive;
   wire [7:0]  intActive;
   wire [7:0]  intEdge;
   wire [15:0] cntA;
   wire [15:0] cntB;
   wire [15:0] cntC;
   wire [15:0] cntD;
   wire        rdStat;
   wire        rdCaught;

   assign regIdx = regAddr[11:2];

   // one edge detector per input
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : gEdge
         ifa_edge_det uEdge (
            .mclk  (mclk),
            .nrst  (nrst),
            .sigIn (inPins[gi]),
            .rise  (rise[gi]),
            .fall  (fall[gi])
         );
      end
   endgenerate

   // first pair on inputs 0..2, from the low-inputs mode register
   ifa_counter_pair uPairLow (
      .mclk          (mclk),
      .nrst          (nrst),
      .modeFirst     (cntLow_q[`IFA_FIRST_LSB +: 4]), // [RQ1]
      .modeSecond    (cntLow_q[`IFA_SECOND_LSB +: 4]), // [RQ6]
      .level         (inPins[2:0]),
      .rise          (rise[2:0]),
      .fall          (fall[2:0]),
      .countFirst_q  (cntA),
      .countSecond_q (cntB),
      .claimed       (claimLow)
   );

   // second pair on inputs 3..5, same mode set
   ifa_counter_pair uPairHigh (
      .mclk          (mclk),
      .nrst          (nrst),
      .modeFirst     (cntHigh_q[`IFA_FIRST_LSB +: 4]), // [RQ7]
      .modeSecond    (cntHigh_q[`IFA_SECOND_LSB +: 4]), // [RQ8]
      .level         (inPins[5:3]),
      .rise          (rise[5:3]),
      .fall          (fall[5:3]),
      .countFirst_q  (cntC),
      .countSecond_q (cntD),
      .claimed       (claimHigh)
   );

   // arbitration: counter beats pulse catch beats interrupt
   assign cntClaim  = {2'b00, claimHigh, claimLow};
   assign pcActive  = pcatch_q & ~cntClaim; // [RQ15] [RQ12]
   assign intActive = intSel_q[`IFA_INT_EN_LSB +: 8] &
                      ~cntClaim & ~pcatch_q; // [RQ15] [RQ13]

   // per-input edge choice: set means falling, clear means rising
   assign intEdge = (fall & intSel_q[`IFA_INT_FALL_LSB +: 8]) | // [RQ14]
                    (rise & ~intSel_q[`IFA_INT_FALL_LSB +: 8]); // [RQ16]

   // raw levels for software, with caught pulses stretched in
   assign inputLevel = inPins | caught_q;

   assign rdStat   = regRd && (regIdx == `IFA_IDX_INTSTAT);
   assign rdCaught = regRd && (regIdx == `IFA_IDX_ROUTE);

   // configuration registers, all clear after reset
   always @(posedge mclk) begin
      if (!nrst) begin
         cntLow_q  <= `IFA_RST_CFG; // [RQ1] [RQ6] [RQ8]
         cntHigh_q <= `IFA_RST_CFG;
         pcatch_q  <= `IFA_RST_BYTE; // [RQ12]
         intSel_q  <= `IFA_RST_CFG; // [RQ13]
         intMask_q <= `IFA_RST_BYTE;
      end else if (regWr) begin
         case (regIdx)
            `IFA_IDX_CNT_LOW:  cntLow_q  <= regWdata[15:0];
            `IFA_IDX_CNT_HIGH: cntHigh_q <= regWdata[15:0];
            `IFA_IDX_PCATCH:   pcatch_q  <= regWdata[7:0];
            `IFA_IDX_INTSEL:   intSel_q  <= regWdata[15:0];
            `IFA_IDX_INTMASK:  intMask_q <= regWdata[7:0];
            default: ;
         endcase
      end
   end

   // pulse catch: hold a seen rising edge until software reads it,
   // so a pulse shorter than the scan is not lost; set beats clear
   always @(posedge mclk) begin
      if (!nrst)
         caught_q <= `IFA_RST_BYTE;
      else if (rdCaught)
         caught_q <= rise & pcActive; // [RQ12]
      else
         caught_q <= caught_q | (rise & pcActive); // [RQ12]
   end

   // interrupt status: sticky, cleared by read, new edge wins
   always @(posedge mclk) begin
      if (!nrst)
         intStat_q <= `IFA_RST_BYTE;
      else if (rdStat)
         intStat_q <= intEdge & intActive; // [RQ13]
      else
         intStat_q <= intStat_q | (intEdge & intActive); // [RQ13]
   end

   assign irq = |(intStat_q & intMask_q);

   // read mux; unmapped addresses read zero
   always @* begin
      rdata_d = 32'h00000000;
      case (regIdx)
         `IFA_IDX_CNT_LOW:  rdata_d = {16'h0000, cntLow_q};
         `IFA_IDX_CNT_HIGH: rdata_d = {16'h0000, cntHigh_q};
         `IFA_IDX_PCATCH:   rdata_d = {24'h000000, pcatch_q};
         `IFA_IDX_INTSEL:   rdata_d = {16'h0000, intSel_q};
         `IFA_IDX_INTSTAT:  rdata_d = {24'h000000, intStat_q};
         `IFA_IDX_INTMASK:  rdata_d = {24'h000000, intMask_q};
         `IFA_IDX_CNTA:     rdata_d = {16'h0000, cntA};
         `IFA_IDX_CNTB:     rdata_d = {16'h0000, cntB};
         `IFA_IDX_CNTC:     rdata_d = {16'h0000, cntC};
         `IFA_IDX_CNTD:     rdata_d = {16'h0000, cntD};
         `IFA_IDX_ROUTE:    rdata_d = {8'h00, caught_q, intActive,
                                       pcActive};
         default:           rdata_d = 32'h00000000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (!nrst)
         regRdata_q <= 32'h00000000;
      else if (regRd)
         regRdata_q <= rdata_d;
      else
         regRdata_q <= 32'h00000000;
   end
endmodule // ifa_input_assign

`default_nettype wire

// ==== verif/ifa_input_assign_checker.sv ====
/* ifa_input_assign_checker.sv: port assertions for ifa_input_assign.
   Assumes it is bound into the top module; sees only its ports. */
`default_nettype none
`include "ifa_defines.vh"
module ifa_input_assign_checker (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  inPins,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata_q,
   input wire logic [7:0]  inputLevel,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [9:0] idx;
   logic [7:0] modeLo_q;
   logic [7:0] modeHi_q;
   logic [7:0] maskSh_q;
   logic       bIgn;
   logic       dIgn;
   // two-input first modes leave the second channel held at 0
   assign idx  = regAddr[11:2];
   assign bIgn = modeLo_q[3:0] inside {4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'hA};
   assign dIgn = modeHi_q[3:0] inside {4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'hA};
   // shadows of bus writes, so reads can be judged against the setup
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         modeLo_q <= 8'h00;
         modeHi_q <= 8'h00;
         maskSh_q <= 8'h00;
      end else if (regWr) begin
         if (idx == `IFA_IDX_CNT_LOW) modeLo_q <= regWdata[7:0];
         if (idx == `IFA_IDX_CNT_HIGH) modeHi_q <= regWdata[7:0];
         if (idx == `IFA_IDX_INTMASK) maskSh_q <= regWdata[7:0];
      end
   end
   sequence wrRd(int i);
      regWr && idx == i ##1 regRd && idx == i;
   endsequence
   // pins quiet long enough that no event can still be in flight
   sequence quietRd;
      $stable(inPins) [*3] ##1 (regRd && idx == `IFA_IDX_INTSTAT
         && $stable(inPins)) [*2];
   endsequence
   chk_rdata_idle: assert property (regRdata_q != 32'h0 |-> $past(regRd))
      else $error("read data outside the answer cycle");
   chk_reset_clear: assert property ($rose(nrst) |->
      regRdata_q == 32'h0 && !irq && inputLevel == inPins)
      else $error("outputs not clear after reset");
   chk_level_cover: assert property ((inPins & ~inputLevel) == 8'h00)
      else $error("input level lost a high pin");
   chk_sel_readback: assert property (wrRd(`IFA_IDX_PCATCH) |=>
      regRdata_q[7:0] == $past(regWdata[7:0], 2))
      else $error("pulse catch select not kept");
   chk_intsel_readback: assert property (wrRd(`IFA_IDX_INTSEL) |=>
      regRdata_q[15:0] == $past(regWdata[15:0], 2))
      else $error("interrupt select not kept");
   chk_stat_clear: assert property (quietRd |=>
      regRdata_q == 32'h0 && !irq)
      else $error("status not cleared by read");
   chk_irq_mask: assert property (irq |-> maskSh_q != 8'h00)
      else $error("interrupt with every source masked");
   chk_a_off: assert property (regRd && idx == `IFA_IDX_CNTA
      && modeLo_q[3:0] == 4'h0 && $stable(modeLo_q) |=> regRdata_q == 0)
      else $error("disabled first channel counts");
   chk_b_ignored: assert property (regRd && idx == `IFA_IDX_CNTB
      && bIgn && $stable(modeLo_q) |=> regRdata_q == 32'h0)
      else $error("second channel not ignored");
   chk_d_ignored: assert property (regRd && idx == `IFA_IDX_CNTD
      && dIgn && $stable(modeHi_q) |=> regRdata_q == 32'h0)
      else $error("fourth channel not ignored");
endmodule // ifa_input_assign_checker
bind ifa_input_assign ifa_input_assign_checker u_chk (.mclk(mclk),
   .nrst(nrst), .inPins(inPins), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
   .inputLevel(inputLevel), .irq(irq));
`default_nettype wire

// ==== verif/ifa_pin_source.sv ====
/* ifa_pin_source.sv: encoders, pulse sources and switches on the inputs.
   Assumes its tasks are called from the bench's main process. */
`default_nettype none
module ifa_pin_source (
   input  wire logic       mclk,
   output var  logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pins = 8'h00;
   // a switch: change one pin just after an edge
   task automatic lvl(input int b, input logic v);
      @(posedge mclk);
      pins[b] <= v;
   endtask
   // n pulses, w cycles high and w low; w above 1 is a slow source
   task automatic pulse(input int b, input int n, input int w);
      repeat (n) begin
         lvl(b, 1'b1);
         repeat (w - 1) @(posedge mclk);
         lvl(b, 1'b0);
         repeat (w - 1) @(posedge mclk);
      end
   endtask
   // forward encoder steps, phase a on pin b, phase b on pin b+1
   task automatic quad(input int b, input int n);
      repeat (n) begin
         lvl(b, 1'b1);
         lvl(b + 1, 1'b1);
         lvl(b, 1'b0);
         lvl(b + 1, 1'b0);
      end
   endtask
endmodule // ifa_pin_source
`default_nettype wire

// ==== verif/input_function_assignment_test.sv ====
/* input_function_assignment_test.sv: self-checking bench of the block.
   Assumes the checker binds itself and the pin source drives inPins. */
`default_nettype none
`include "ifa_defines.vh"
module input_function_assignment_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        rdV = 1'b0;
   wire  [7:0]  inPins;
   wire  [31:0] regRdata_q;
   wire  [7:0]  inputLevel;
   wire         irq;
   logic [31:0] expQ[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          n;
   ifa_pin_source src (.mclk(mclk), .pins(inPins));
   ifa_input_assign dut (.mclk(mclk), .nrst(nrst), .inPins(inPins),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata_q(regRdata_q), .inputLevel(inputLevel),
      .irq(irq));
   // 40 ns period
   always #20 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one bus cycle; a read notes its expected data in the queue
   task automatic acc(input logic w, input logic [9:0] i,
                      input logic [31:0] d);
      @(posedge mclk);
      regWr <= w;
      regRd <= !w;
      regAddr <= {i, 2'b00};
      regWdata <= d;
      if (!w)
         expQ.push_back(d);
   endtask
   // drop strobes, wait k edges, then step off the edge to sample
   task automatic idle(input int k);
      @(posedge mclk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // passing through off clears the count before the new mode
   task automatic setm(input logic [9:0] r, input logic [31:0] c);
      acc(1'b1, r, 32'h0);
      acc(1'b1, r, c);
      idle(1);
   endtask
   task automatic pair_test(input int p);
      logic [9:0] mr;
      logic [9:0] ca;
      int b;
      mr = 10'(`IFA_IDX_CNT_LOW + p);
      ca = 10'(`IFA_IDX_CNTA + 2 * p);
      b = 3 * p;
      n = $urandom_range(9, 1);
      setm(mr, 32'h03);
      src.pulse(b, n, 1);
      acc(1'b0, ca, n);
      setm(mr, 32'h05);
      src.pulse(b, n, 2);
      acc(1'b0, ca, {16'h0, 16'(-n)});
      setm(mr, 32'h04);
      src.lvl(b + 2, 1'b1);
      src.pulse(b, n, 1);
      acc(1'b0, ca, 32'h0);
      setm(mr, 32'h24);
      src.pulse(b, n, 1);
      src.pulse(b + 1, 2, 1);
      acc(1'b0, ca, n);
      acc(1'b0, ca + 1, 32'h0);
      setm(mr, 32'h02);
      src.quad(b, 2);
      src.lvl(b + 2, 1'b0);
      acc(1'b0, ca, 32'h0);
      setm(mr, 32'h11);
      src.quad(b, n);
      acc(1'b0, ca, 2 * n);
      acc(1'b0, ca + 1, 32'h0);
      setm(mr, 32'h07);
      src.pulse(b, 3, 1);
      src.pulse(b + 1, 2, 1);
      acc(1'b0, ca, 32'h1);
      setm(mr, 32'h09);
      src.lvl(b + 1, 1'b1);
      src.pulse(b, 4, 1);
      src.lvl(b + 1, 1'b0);
      acc(1'b0, ca, 32'hFFFC);
      setm(mr, 32'h30);
      src.pulse(b + 1, n, 1);
      acc(1'b0, ca + 1, {16'h0, 16'(-n)});
      // both claim the reset: low first, then the second channel takes it
      setm(mr, 32'h46);
      src.pulse(b, n, 1);
      src.pulse(b + 1, 2, 1);
      acc(1'b0, ca + 1, 32'hFFFE);
      idle(1);
      src.lvl(b + 2, 1'b1);
      idle(1);
      acc(1'b0, ca, {16'h0, 16'(-n)});
      acc(1'b0, ca + 1, 32'h0);
      setm(mr, 32'h18);
      src.pulse(b, 3, 1);
      src.pulse(b + 1, 2, 1);
      acc(1'b0, ca, 32'h0);
      setm(mr, 32'h0A);
      src.pulse(b, 2, 1);
      src.lvl(b + 2, 1'b0);
      src.pulse(b, 3, 1);
      acc(1'b0, ca, 32'h3);
      setm(mr, 32'h00);
      $display("test pair %0d done", p);
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge mclk)
      rdV <= regRd && nrst;
   always @(negedge mclk)
      if (rdV)
         check(regRdata_q, expQ.pop_front());
   // cut a hang short
   initial begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      $display("wrong value at %0t: run too long", $time);
      results;
   end
   initial begin
      void'($urandom(49863));
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 'h190; i <= 'h19A; i++)
         acc(1'b0, 10'(i), 32'h0);
      acc(1'b0, 10'h1A0, 32'h0);
      n = $urandom_range(255, 0);
      acc(1'b1, `IFA_IDX_PCATCH, n);
      acc(1'b0, `IFA_IDX_PCATCH, n);
      n = $urandom_range(65535, 0);
      acc(1'b1, `IFA_IDX_INTSEL, n);
      acc(1'b0, `IFA_IDX_INTSEL, n);
      acc(1'b1, `IFA_IDX_CNTA, 32'h1234);
      acc(1'b0, `IFA_IDX_CNTA, 32'h0);
      acc(1'b1, `IFA_IDX_PCATCH, 32'h0);
      acc(1'b1, `IFA_IDX_INTSEL, 32'h0);
      idle(1);
      $display("test registers done");
      pair_test(0);
      pair_test(1);
      acc(1'b1, `IFA_IDX_CNT_LOW, 32'h13);
      acc(1'b1, `IFA_IDX_PCATCH, 32'h21);
      acc(1'b1, `IFA_IDX_INTSEL, 32'h80F1);
      acc(1'b1, `IFA_IDX_INTMASK, 32'hC1);
      idle(1);
      src.pulse(0, 2, 1);
      src.pulse(1, 1, 1);
      src.pulse(4, 1, 1);
      src.pulse(5, 1, 3);
      idle(3);
      check(irq, 1'b0);
      check(inputLevel, 8'h20);
      acc(1'b0, `IFA_IDX_ROUTE, 32'h0020D020);
      acc(1'b0, `IFA_IDX_INTSTAT, 32'h10);
      acc(1'b0, `IFA_IDX_CNTA, 32'h2);
      acc(1'b0, `IFA_IDX_CNTB, 32'h1);
      idle(1);
      check(inputLevel, 8'h00);
      src.lvl(7, 1'b1);
      idle(3);
      check(irq, 1'b0);
      src.lvl(7, 1'b0);
      src.pulse(6, 1, 1);
      idle(3);
      check(irq, 1'b1);
      acc(1'b0, `IFA_IDX_INTSTAT, 32'hC0);
      acc(1'b0, `IFA_IDX_INTSTAT, 32'h0);
      idle(1);
      check(irq, 1'b0);
      $display("test interrupts done");
      idle(2);
      check(expQ.size(), 32'h0);
      results;
   end
endmodule // input_function_assignment_test
`default_nettype wire
